// >>> logic/bss_sequencer.sv
// Startup phase sequencer of a lamp ballast controller, lockout through run mode.
// Assumes comparator results arrive asynchronously; frequency and preheat codes are
// static values from logic on the same clock. reset_i stands for supply lockout.
`timescale 1ns/100ps
module bss_sequencer #(
  parameter int US_DIV = bss_pkg::US_DIV,
  parameter int BUSCHK_US = bss_pkg::T_BUSCHK_US,
  parameter int PFC_DLY_US = bss_pkg::T_PFC_DLY_US,
  parameter int BUS95_US = bss_pkg::T_BUS95_MS * bss_pkg::MS_US,
  parameter int SOFT_US = bss_pkg::T_SOFT_MS * bss_pkg::MS_US,
  parameter int PH_STEP_US = bss_pkg::T_PREHEAT_MAX_MS * bss_pkg::MS_US / bss_pkg::PREHEAT_STEPS,
  parameter int IGN_SWEEP_US = bss_pkg::T_IGN_SWEEP_MS * bss_pkg::MS_US,
  parameter int IGN_MAX_US = bss_pkg::T_IGN_MAX_MS * bss_pkg::MS_US,
  parameter int PRERUN_US = bss_pkg::T_PRERUN_MS * bss_pkg::MS_US
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic vcc_above_on_i,
  input wire logic vcc_above_start_i,
  input wire logic bus_above_open_loop_i,
  input wire logic bus_below_overvolt_i,
  input wire logic bus_above_95_i,
  input wire logic lamp_voltage_sense_pin_sink_i,
  input wire logic restart_sense_pin_above_high_i,
  input wire logic restart_sense_pin_above_low_i,
  input wire logic low_side_current_sense_slope_i,
  input wire logic low_side_current_sense_above_i,
  input wire logic lamp_ignited_i,
  input wire logic [bss_pkg::FREQ_W-1:0] preheat_frequency_set_i,
  input wire logic [bss_pkg::FREQ_W-1:0] run_frequency_set_i,
  input wire logic [bss_pkg::PH_SET_W-1:0] preheat_time_set_i,
  output logic inv_gate_en_o,
  output logic pfc_gate_en_o,
  output logic [bss_pkg::FREQ_W-1:0] freq_target_o,
  output logic [bss_pkg::N_ST-1:0] state_o,
  output logic ignition_ctrl_en_o,
  output logic run_monitor_en_o,
  output logic restart_threshold_low_o,
  output logic restart_source_high_o,
  output logic ls_filament_open_o,
  output logic hs_filament_open_o,
  output logic fault_latched_o
);
  localparam int NI = bss_pkg::N_IN;
  localparam int DW = bss_pkg::US_DIV_W;
  localparam int FW = bss_pkg::FREQ_W;

  logic [NI-1:0] pin_raw;
  logic [NI-1:0] s1_reg;
  logic [NI-1:0] s2_reg;
  logic [NI-1:0] s3_reg;
  logic [NI-1:0] flt_reg;

  assign pin_raw[bss_pkg::IN_VCC_ON] = vcc_above_on_i;
  assign pin_raw[bss_pkg::IN_VCC_START] = vcc_above_start_i;
  assign pin_raw[bss_pkg::IN_BUS_LOW] = bus_above_open_loop_i;
  assign pin_raw[bss_pkg::IN_BUS_HIGH] = bus_below_overvolt_i;
  assign pin_raw[bss_pkg::IN_BUS95] = bus_above_95_i;
  assign pin_raw[bss_pkg::IN_LVS] = lamp_voltage_sense_pin_sink_i;
  assign pin_raw[bss_pkg::IN_RES_HI] = restart_sense_pin_above_high_i;
  assign pin_raw[bss_pkg::IN_RES_LO] = restart_sense_pin_above_low_i;
  assign pin_raw[bss_pkg::IN_LOW_SIDE_CURRENT_SENSE_SLOPE] = low_side_current_sense_slope_i;
  assign pin_raw[bss_pkg::IN_LOW_SIDE_CURRENT_SENSE_LVL] = low_side_current_sense_above_i;
  assign pin_raw[bss_pkg::IN_IGNITED] = lamp_ignited_i;

  // Three-stage synchroniser; a level is accepted once stages two and three agree
  for (genvar i = 0; i < NI; i++) begin : g_sync
    always_ff @(posedge ref_clk_i) begin
      s1_reg[i] <= pin_raw[i];
      s2_reg[i] <= s1_reg[i];
      s3_reg[i] <= s2_reg[i];
    end
    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        flt_reg[i] <= 1'b0;
      end else if (s2_reg[i] == s3_reg[i]) begin
        flt_reg[i] <= s3_reg[i];
      end
    end
  end

  logic vcc_on, vcc_start, corridor_ok, bus95, lvs_sink, res_hi, res_lo, low_side_current_sense_trip, ignited;
  assign vcc_on = flt_reg[bss_pkg::IN_VCC_ON];
  assign vcc_start = flt_reg[bss_pkg::IN_VCC_START];
  assign corridor_ok = flt_reg[bss_pkg::IN_BUS_LOW] && flt_reg[bss_pkg::IN_BUS_HIGH];
  assign bus95 = flt_reg[bss_pkg::IN_BUS95];
  assign lvs_sink = flt_reg[bss_pkg::IN_LVS];
  assign res_hi = flt_reg[bss_pkg::IN_RES_HI];
  assign res_lo = flt_reg[bss_pkg::IN_RES_LO];
  assign low_side_current_sense_trip = flt_reg[bss_pkg::IN_LOW_SIDE_CURRENT_SENSE_SLOPE] && flt_reg[bss_pkg::IN_LOW_SIDE_CURRENT_SENSE_LVL];
  assign ignited = flt_reg[bss_pkg::IN_IGNITED];

  // 1 us enable
  logic [DW-1:0] div_reg;
  logic us_tick;
  assign us_tick = div_reg == DW'(US_DIV - 1);
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || us_tick) div_reg <= '0;
    else div_reg <= DW'(div_reg + 1'b1);
  end

  bss_pkg::bss_state_t state_reg, state_next;
  bss_pkg::bss_tmr_t tmr_reg, pwr_us_reg, preheat_us;
  logic res_open_reg, hold_reg, inv_reg, pfc_reg;
  logic [FW-1:0] freq_reg;

  logic st_uvlo, st_detect, st_buschk, st_start, st_soft, st_preheat, st_ignite, st_prerun;
  assign st_uvlo = state_reg == bss_pkg::ST_UVLO;
  assign st_detect = state_reg == bss_pkg::ST_DETECT;
  assign st_buschk = state_reg == bss_pkg::ST_BUSCHK;
  assign st_start = state_reg == bss_pkg::ST_START;
  assign st_soft = state_reg == bss_pkg::ST_SOFT;
  assign st_preheat = state_reg == bss_pkg::ST_PREHEAT;
  assign st_ignite = state_reg == bss_pkg::ST_IGNITE;
  assign st_prerun = state_reg == bss_pkg::ST_PRERUN;

  logic in_detect, fil_ok, buschk_done, bus95_late, preheat_done, ign_late, prerun_done;
  assign in_detect = st_detect || st_buschk;
  assign fil_ok = lvs_sink && !res_open_reg;
  assign preheat_us = bss_pkg::bss_tmr_t'(preheat_time_set_i * PH_STEP_US);
  assign buschk_done = tmr_reg >= bss_pkg::bss_tmr_t'(BUSCHK_US);
  assign bus95_late = tmr_reg >= bss_pkg::bss_tmr_t'(BUS95_US);
  assign preheat_done = tmr_reg >= preheat_us;
  assign ign_late = tmr_reg >= bss_pkg::bss_tmr_t'(IGN_MAX_US);
  assign prerun_done = tmr_reg >= bss_pkg::bss_tmr_t'(PRERUN_US);

  bss_ramp_if ramp_bus ();
  logic ramp_done;
  assign ramp_done = ramp_bus.done;

  always_comb begin
    state_next = state_reg;
    if (!vcc_on) begin
      state_next = bss_pkg::ST_UVLO;
    end else begin
      case (state_reg)
        bss_pkg::ST_UVLO: state_next = bss_pkg::ST_DETECT;
        bss_pkg::ST_DETECT: if (vcc_start) state_next = bss_pkg::ST_BUSCHK;
        bss_pkg::ST_BUSCHK: begin
          if (buschk_done && !corridor_ok) state_next = bss_pkg::ST_LOCKOUT;
          else if (buschk_done && fil_ok) state_next = bss_pkg::ST_START;
        end
        bss_pkg::ST_LOCKOUT: state_next = bss_pkg::ST_LOCKOUT;
        bss_pkg::ST_START: begin
          if (bus95) state_next = bss_pkg::ST_SOFT;
          else if (bus95_late) state_next = bss_pkg::ST_FAULT;
        end
        bss_pkg::ST_SOFT: if (ramp_done) state_next = bss_pkg::ST_PREHEAT;
        bss_pkg::ST_PREHEAT: if (preheat_done) state_next = bss_pkg::ST_IGNITE;
        bss_pkg::ST_IGNITE: begin
          if (ignited) state_next = bss_pkg::ST_PRERUN;
          else if (ign_late) state_next = bss_pkg::ST_FAULT;
        end
        bss_pkg::ST_PRERUN: if (prerun_done) state_next = bss_pkg::ST_RUN;
        bss_pkg::ST_RUN: state_next = bss_pkg::ST_RUN;
        bss_pkg::ST_FAULT: state_next = bss_pkg::ST_FAULT;
        default: state_next = bss_pkg::ST_UVLO;
      endcase
    end
  end

  logic changing, powered_next, ramp_to_soft, ramp_to_ign;
  assign changing = state_next != state_reg;
  assign powered_next = |(state_next & (bss_pkg::ST_START | bss_pkg::ST_SOFT |
                        bss_pkg::ST_PREHEAT | bss_pkg::ST_IGNITE | bss_pkg::ST_PRERUN |
                        bss_pkg::ST_RUN));
  assign ramp_to_soft = changing && state_next == bss_pkg::ST_SOFT;
  assign ramp_to_ign = changing && state_next == bss_pkg::ST_IGNITE;

  assign ramp_bus.start = ramp_to_soft || ramp_to_ign;
  assign ramp_bus.from_freq = ramp_to_soft ? bss_pkg::F_START : preheat_frequency_set_i;
  assign ramp_bus.to_freq = ramp_to_soft ? preheat_frequency_set_i : run_frequency_set_i;
  assign ramp_bus.dur_us = bss_pkg::bss_tmr_t'(ramp_to_soft ? SOFT_US : IGN_SWEEP_US);
  assign ramp_bus.tick = us_tick;
  assign ramp_bus.hold = hold_reg;

  bss_freq_ramp u_ramp (
    .ref_clk_i (ref_clk_i),
    .reset_i (reset_i),
    .rb (ramp_bus.ramp)
  );

  // Open filament latch; a new trip wins over the release in the same cycle
  logic res_set, res_clr, res_open_next, hold_next, pfc_next;
  assign res_set = in_detect && !res_open_reg && res_hi;
  assign res_clr = st_uvlo || !res_lo;
  assign res_open_next = res_set || (res_open_reg && !res_clr);
  assign hold_next = st_ignite && !changing && (hold_reg || low_side_current_sense_trip);
  assign pfc_next = powered_next && (pwr_us_reg >= bss_pkg::bss_tmr_t'(PFC_DLY_US));

  logic [FW-1:0] freq_sel;
  always_comb begin
    case (state_reg)
      bss_pkg::ST_START: freq_sel = bss_pkg::F_START;
      bss_pkg::ST_SOFT: freq_sel = ramp_bus.cur_freq;
      bss_pkg::ST_PREHEAT: freq_sel = preheat_frequency_set_i;
      bss_pkg::ST_IGNITE: freq_sel = ramp_bus.cur_freq;
      bss_pkg::ST_PRERUN: freq_sel = run_frequency_set_i;
      bss_pkg::ST_RUN: freq_sel = run_frequency_set_i;
      default: freq_sel = bss_pkg::F_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg <= bss_pkg::ST_UVLO;
      tmr_reg <= bss_pkg::TMR_ZERO;
      pwr_us_reg <= bss_pkg::TMR_ZERO;
      res_open_reg <= 1'b0;
      hold_reg <= 1'b0;
      inv_reg <= 1'b0;
      pfc_reg <= 1'b0;
      freq_reg <= bss_pkg::F_IDLE;
    end else begin
      state_reg <= state_next;
      if (changing) tmr_reg <= bss_pkg::TMR_ZERO;
      else if (us_tick && !(&tmr_reg)) tmr_reg <= bss_pkg::bss_tmr_t'(tmr_reg + 1'b1);
      if (!powered_next) pwr_us_reg <= bss_pkg::TMR_ZERO;
      else if (us_tick && !pfc_next) pwr_us_reg <= bss_pkg::bss_tmr_t'(pwr_us_reg + 1'b1);
      res_open_reg <= res_open_next;
      hold_reg <= hold_next;
      inv_reg <= powered_next;
      pfc_reg <= pfc_next;
      freq_reg <= freq_sel;
    end
  end

  assign inv_gate_en_o = inv_reg;
  assign pfc_gate_en_o = pfc_reg;
  assign freq_target_o = freq_reg;
  assign state_o = state_reg;
  assign ignition_ctrl_en_o = st_ignite;
  assign run_monitor_en_o = state_reg == bss_pkg::ST_RUN;
  assign restart_threshold_low_o = res_open_reg;
  assign restart_source_high_o = in_detect && !lvs_sink;
  assign hs_filament_open_o = in_detect && !lvs_sink;
  assign ls_filament_open_o = res_open_reg && lvs_sink;
  assign fault_latched_o = state_reg == bss_pkg::ST_FAULT;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  chk_supply_loss_off: assert property (!vcc_on |=> st_uvlo ##1 !inv_gate_en_o)
    else $error("gates or state not back to lockout after supply loss");
  chk_corridor_lockout: assert property (st_buschk && vcc_on && buschk_done && !corridor_ok
    |=> state_reg == bss_pkg::ST_LOCKOUT ##1 !inv_gate_en_o && !pfc_gate_en_o)
    else $error("corridor failure did not force lockout");
  chk_no_early_check: assert property (st_buschk && tmr_reg < bss_pkg::bss_tmr_t'(BUSCHK_US)
    |=> !st_start)
    else $error("power-up before bus check delay");
  chk_powerup_cond: assert property (st_buschk && !fil_ok |=> !st_start)
    else $error("power-up with defective filament");
  chk_start_freq: assert property (st_start && $past(st_start) |-> freq_target_o == bss_pkg::F_START
    && inv_gate_en_o)
    else $error("start frequency or inverter gate wrong");
  chk_pfc_delay: assert property ($rose(pfc_gate_en_o) |-> inv_gate_en_o &&
    $past(pwr_us_reg) >= bss_pkg::bss_tmr_t'(PFC_DLY_US))
    else $error("PFC enabled before its delay");
  chk_bus95_window: assert property (st_start && vcc_on && !bus95 && bus95_late
    |=> fault_latched_o ##1 !inv_gate_en_o && !pfc_gate_en_o)
    else $error("phase 3 timeout not taken as fault");
  chk_preheat_len: assert property (st_preheat && vcc_on && preheat_done |=> st_ignite)
    else $error("preheat did not end on time");
  chk_sweep_halt: assert property (st_ignite && hold_reg && $past(hold_reg) |=> $stable(freq_target_o)
    || !st_ignite)
    else $error("frequency moved after halt");
  chk_ign_timeout: assert property (st_ignite && vcc_on && !ignited && ign_late
    |=> fault_latched_o && !ignition_ctrl_en_o)
    else $error("ignition timeout not latched");
  chk_prerun_len: assert property (st_prerun && vcc_on && !prerun_done |=> !run_monitor_en_o)
    else $error("run monitoring before pre-run end");
  chk_ls_flag: assert property (in_detect && !res_open_reg && res_hi |=> restart_threshold_low_o)
    else $error("open filament not flagged");
  chk_hs_source: assert property (in_detect && !lvs_sink |-> restart_source_high_o)
    else $error("source current not raised");

  cov_reach_run: cover property (st_prerun ##1 run_monitor_en_o);
  cov_lockout: cover property (st_buschk ##1 state_reg == bss_pkg::ST_LOCKOUT);
  cov_ign_fault: cover property (st_ignite ##1 fault_latched_o);
  cov_fil_recover: cover property (res_open_reg ##1 !res_open_reg ##[1:20] st_start);
endmodule

// >>> inc/bss_pkg.sv
// Shared constants, timing figures and state encoding of the ballast startup sequencer.
// Assumes a single 100 MHz clock; every time below is turned into ticks of a 1 us enable.
package bss_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_DIV = US_NS / CLK_PERIOD_NS;
  localparam int US_DIV_W = 7;
  localparam int MS_US = 1000;

  localparam int T_BUSCHK_US = 130;
  localparam int T_PFC_DLY_US = 300;
  localparam int T_BUS95_MS = 80;
  localparam int T_SOFT_MS = 10;
  localparam int T_PREHEAT_MAX_MS = 2500;
  localparam int PREHEAT_STEPS = 127;
  localparam int T_IGN_SWEEP_MS = 40;
  localparam int T_IGN_MAX_MS = 237;
  localparam int T_PRERUN_MS = 625;

  localparam int FREQ_W = 16;
  localparam int FREQ_UNIT_HZ = 100;
  localparam int F_START_KHZ = 135;
  localparam logic [FREQ_W-1:0] F_START = FREQ_W'(F_START_KHZ * 1000 / FREQ_UNIT_HZ);
  localparam logic [FREQ_W-1:0] F_IDLE = 16'h0000;

  localparam int TMR_W = 22;
  localparam int PH_SET_W = 7;
  typedef logic [TMR_W-1:0] bss_tmr_t;
  localparam bss_tmr_t TMR_ZERO = 22'h000000;

  localparam int IN_VCC_ON = 0;
  localparam int IN_VCC_START = 1;
  localparam int IN_BUS_LOW = 2;
  localparam int IN_BUS_HIGH = 3;
  localparam int IN_BUS95 = 4;
  localparam int IN_LVS = 5;
  localparam int IN_RES_HI = 6;
  localparam int IN_RES_LO = 7;
  localparam int IN_LOW_SIDE_CURRENT_SENSE_SLOPE = 8;
  localparam int IN_LOW_SIDE_CURRENT_SENSE_LVL = 9;
  localparam int IN_IGNITED = 10;
  localparam int N_IN = 11;

  localparam int N_ST = 11;
  typedef enum logic [N_ST-1:0] {
    ST_UVLO    = 11'h001,
    ST_DETECT  = 11'h002,
    ST_BUSCHK  = 11'h004,
    ST_LOCKOUT = 11'h008,
    ST_START   = 11'h010,
    ST_SOFT    = 11'h020,
    ST_PREHEAT = 11'h040,
    ST_IGNITE  = 11'h080,
    ST_PRERUN  = 11'h100,
    ST_RUN     = 11'h200,
    ST_FAULT   = 11'h400
  } bss_state_t;
endpackage

// >>> inc/bss_ramp_if.sv
// Carrier between the sequencer and its frequency ramp generator.
// Assumes both ends share ref_clk_i; the sequencer drives the control side.
`timescale 1ns/100ps
interface bss_ramp_if;
  logic start;
  logic hold;
  logic tick;
  logic done;
  logic [bss_pkg::FREQ_W-1:0] from_freq;
  logic [bss_pkg::FREQ_W-1:0] to_freq;
  logic [bss_pkg::FREQ_W-1:0] cur_freq;
  logic [bss_pkg::TMR_W-1:0] dur_us;
  modport ctrl (output start, hold, tick, from_freq, to_freq, dur_us, input done, cur_freq);
  modport ramp (input start, hold, tick, from_freq, to_freq, dur_us, output done, cur_freq);
endinterface

// >>> logic/bss_freq_ramp.sv
// Downward frequency ramp: spreads the span between two frequencies over a duration in us.
// Assumes start is a one-cycle pulse and tick a 1 us enable from the sequencer.
`timescale 1ns/100ps
module bss_freq_ramp (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  bss_ramp_if.ramp rb
);
  localparam int FW = bss_pkg::FREQ_W;
  localparam int AW = bss_pkg::TMR_W + 1;

  logic active_reg;
  logic [FW-1:0] cur_reg;
  logic [FW-1:0] to_reg;
  logic [FW-1:0] span_reg;
  logic [AW-1:0] dur_reg;
  logic [AW-1:0] acc_reg;
  logic [AW-1:0] acc_sum;
  logic step;
  logic arrived;

  assign acc_sum = acc_reg + AW'(span_reg);
  assign step = acc_sum >= dur_reg;
  assign arrived = cur_reg <= to_reg;
  assign rb.done = active_reg && !rb.start && arrived;
  assign rb.cur_freq = cur_reg;

  // Bresenham stepping keeps the total sweep time near the requested duration
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      active_reg <= 1'b0;
      cur_reg <= bss_pkg::F_IDLE;
      to_reg <= bss_pkg::F_IDLE;
      span_reg <= bss_pkg::F_IDLE;
      dur_reg <= '0;
      acc_reg <= '0;
    end else if (rb.start) begin
      active_reg <= 1'b1;
      cur_reg <= rb.from_freq;
      to_reg <= rb.to_freq;
      span_reg <= (rb.from_freq > rb.to_freq) ? FW'(rb.from_freq - rb.to_freq) : bss_pkg::F_IDLE;
      dur_reg <= AW'(rb.dur_us);
      acc_reg <= '0;
    end else if (active_reg && rb.tick && !rb.hold && !arrived) begin
      if (step) begin
        acc_reg <= AW'(acc_sum - dur_reg);
        cur_reg <= FW'(cur_reg - 1'b1);
      end else begin
        acc_reg <= acc_sum;
      end
    end
  end

  chk_ramp_never_up: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (active_reg && !rb.start) |=> (cur_reg <= $past(cur_reg)))
    else $error("ramp frequency went up");
  chk_ramp_hold_freeze: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rb.hold && !rb.start) |=> $stable(cur_reg))
    else $error("ramp moved while held");
endmodule

// >>> dv/bss_plant_model.sv
// Behavioural half-bridge, bus, lamp filaments and sense networks for the sequencer.
// Assumes the sequencer's clock; the bench sets the scenario knobs.
`timescale 1ns/100ps
module bss_plant_model (
  input wire logic ref_clk_i,
  input wire logic inv_en_i,
  input wire logic pfc_en_i,
  input wire logic ign_en_i,
  input wire logic src_high_i,
  input wire logic ls_ok_i,
  input wire logic hs_ok_i,
  input wire logic bus_ok_i,
  input wire logic lamp_ok_i,
  input wire logic reson_i,
  output logic bus95_o,
  output logic sink_o,
  output logic res_hi_o,
  output logic res_lo_o,
  output logic slope_o,
  output logic lvl_o,
  output logic ignited_o
);
  int bus_cnt = 0;
  int ign_cnt = 0;
  int dis_cnt = 40;
  // Open filament, or raised source with no sink, charges the pin past both thresholds
  assign res_hi_o = !ls_ok_i || (src_high_i && !hs_ok_i);
  assign sink_o = hs_ok_i;
  // The pin capacitor takes a while to fall from the upper to the lower threshold
  assign res_lo_o = res_hi_o || dis_cnt < 40;
  // Bus needs the PFC running a while; it collapses when the PFC stops
  assign bus95_o = bus_ok_i && bus_cnt > 100;
  assign slope_o = reson_i && ign_cnt > 50;
  assign lvl_o = reson_i && ign_cnt > 30;
  assign ignited_o = lamp_ok_i && ign_cnt > 150;
  always @(posedge ref_clk_i) begin
    bus_cnt <= pfc_en_i ? bus_cnt + 1 : 0;
    ign_cnt <= (inv_en_i && (ign_en_i || ignited_o)) ? ign_cnt + 1 : 0;
    dis_cnt <= res_hi_o ? 0 : ((dis_cnt < 40) ? dis_cnt + 1 : dis_cnt);
  end
endmodule

// >>> dv/testbench.sv
// Self-checking bench of the ballast startup sequencer with shortened timers.
// Assumes 1 us = 4 cycles; the plant model answers the sense inputs.
`timescale 1ns/100ps
module testbench;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic vcc_on = 1'b0, vcc_st = 1'b0, bus_lo = 1'b1, bus_hi = 1'b1;
  logic ls_ok = 1'b1, hs_ok = 1'b1, bus_ok = 1'b1, lamp_ok = 1'b1, reson = 1'b0;
  logic [bss_pkg::PH_SET_W-1:0] ph_time = 7'h00;
  logic [bss_pkg::FREQ_W-1:0] ph_freq = 16'h0532, run_freq = 16'h001e, freq, f0;
  logic inv_en, pfc_en, ign_en, run_mon, thr_low, src_hi, ls_open, hs_open, fault;
  logic bus95, sink, res_hi, res_lo, slope, lvl, ignited;
  logic [bss_pkg::N_ST-1:0] state;
  int n_fail = 0;
  int num_checks = 0;
  int c;
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Bus check, PFC delay, preheat step and ignition sweep keep their full-scale values
  bss_sequencer #(.US_DIV(4), .BUS95_US(400), .SOFT_US(50), .IGN_MAX_US(400),
    .PRERUN_US(50)) dut_u (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .vcc_above_on_i(vcc_on),
    .vcc_above_start_i(vcc_st), .bus_above_open_loop_i(bus_lo), .bus_below_overvolt_i(bus_hi),
    .bus_above_95_i(bus95), .lamp_voltage_sense_pin_sink_i(sink),
    .restart_sense_pin_above_high_i(res_hi), .restart_sense_pin_above_low_i(res_lo),
    .low_side_current_sense_slope_i(slope), .low_side_current_sense_above_i(lvl),
    .lamp_ignited_i(ignited), .preheat_frequency_set_i(ph_freq),
    .run_frequency_set_i(run_freq), .preheat_time_set_i(ph_time), .inv_gate_en_o(inv_en),
    .pfc_gate_en_o(pfc_en), .freq_target_o(freq), .state_o(state),
    .ignition_ctrl_en_o(ign_en), .run_monitor_en_o(run_mon),
    .restart_threshold_low_o(thr_low), .restart_source_high_o(src_hi),
    .ls_filament_open_o(ls_open), .hs_filament_open_o(hs_open), .fault_latched_o(fault));
  bss_plant_model plant_u (.ref_clk_i(ref_clk_i), .inv_en_i(inv_en), .pfc_en_i(pfc_en),
    .ign_en_i(ign_en), .src_high_i(src_hi), .ls_ok_i(ls_ok), .hs_ok_i(hs_ok),
    .bus_ok_i(bus_ok), .lamp_ok_i(lamp_ok), .reson_i(reson), .bus95_o(bus95),
    .sink_o(sink), .res_hi_o(res_hi), .res_lo_o(res_lo), .slope_o(slope), .lvl_o(lvl),
    .ignited_o(ignited));
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wait_st(input bss_pkg::bss_state_t s, input int lim);
    c = 0;
    while (state !== s && c < lim) begin
      cyc(1);
      c++;
    end
    chk(state === s, "state not reached in time");
  endtask
  // Drops supply and restores a healthy plant
  task automatic off();
    vcc_on <= 1'b0;
    vcc_st <= 1'b0;
    {bus_lo, bus_hi, ls_ok, hs_ok, bus_ok, lamp_ok, reson} <= 7'h7e;
    cyc(8);
  endtask
  task automatic on(input bit st);
    vcc_on <= 1'b1;
    wait_st(bss_pkg::ST_DETECT, 12);
    if (st) begin
      vcc_st <= 1'b1;
      wait_st(bss_pkg::ST_BUSCHK, 12);
    end
  endtask
  task automatic t_normal();
    off();
    on(1);
    wait_st(bss_pkg::ST_START, 600);
    chk(c >= 4 * (bss_pkg::T_BUSCHK_US - 1) && pfc_en === 1'b0,
      "bus check too short");
    cyc(2);
    chk(inv_en === 1'b1 && freq === bss_pkg::F_START, "start frequency");
    c = 0;
    while (pfc_en !== 1'b1 && c < 1300) begin
      cyc(1);
      c++;
    end
    chk(c >= 4 * bss_pkg::T_PFC_DLY_US - 8 && c <= 4 * bss_pkg::T_PFC_DLY_US,
      "pfc delay");
    wait_st(bss_pkg::ST_SOFT, 900);
    wait_st(bss_pkg::ST_PREHEAT, 400);
    chk(freq === ph_freq, "soft start end frequency");
    // A zero preheat code leaves the preheat phase after a single cycle
    wait_st(bss_pkg::ST_IGNITE, 200);
    chk(c == 1, "preheat length");
    cyc(140);
    chk(ign_en === 1'b1 && freq < ph_freq && freq > run_freq, "ignition sweep");
    chk(run_mon === 1'b0, "monitoring before run");
    wait_st(bss_pkg::ST_PRERUN, 400);
    wait_st(bss_pkg::ST_RUN, 300);
    chk(c >= 190 && c <= 210, "pre-run length");
    chk(run_mon === 1'b1 && ign_en === 1'b0, "run monitoring");
    vcc_on <= 1'b0;
    wait_st(bss_pkg::ST_UVLO, 10);
    cyc(2);
    chk(inv_en === 1'b0 && pfc_en === 1'b0 && freq === 16'h0000, "gates after loss");
  endtask
  task automatic t_corridor();
    for (int i = 0; i < 2; i++) begin
      off();
      bus_lo <= i[0];
      bus_hi <= !i[0];
      on(1);
      wait_st(bss_pkg::ST_LOCKOUT, 600);
      {bus_lo, bus_hi} <= 2'h3;
      cyc(40);
      chk(state === bss_pkg::ST_LOCKOUT && inv_en === 1'b0 && pfc_en === 1'b0, "lockout");
      vcc_on <= 1'b0;
      wait_st(bss_pkg::ST_UVLO, 10);
    end
  endtask
  task automatic t_filament(input bit hs);
    off();
    ls_ok <= hs;
    hs_ok <= !hs;
    on(0);
    cyc(12);
    chk(thr_low === 1'b1 && ls_open === !hs, "low-side flag");
    chk(hs_open === hs && src_hi === hs, "high-side flag");
    vcc_st <= 1'b1;
    cyc(600);
    chk(state === bss_pkg::ST_BUSCHK && inv_en === 1'b0, "power-up withheld");
    {ls_ok, hs_ok} <= 2'h3;
    cyc(20);
    chk(state === bss_pkg::ST_BUSCHK && thr_low === 1'b1, "left lower threshold early");
    wait_st(bss_pkg::ST_START, 60);
    chk(thr_low === 1'b0, "threshold restored");
  endtask
  task automatic t_bus95();
    off();
    bus_ok <= 1'b0;
    on(1);
    wait_st(bss_pkg::ST_START, 600);
    wait_st(bss_pkg::ST_FAULT, 1640);
    chk(c >= 1596, "bus window length");
    cyc(2);
    chk(inv_en === 1'b0 && pfc_en === 1'b0 && fault === 1'b1, "bus fault gates");
  endtask
  task automatic t_ignite();
    off();
    lamp_ok <= 1'b0;
    reson <= 1'b1;
    on(1);
    wait_st(bss_pkg::ST_IGNITE, 2400);
    cyc(100);
    f0 = freq;
    cyc(200);
    chk(freq === f0 && freq > run_freq, "sweep not halted");
    wait_st(bss_pkg::ST_FAULT, 1340);
    chk(c >= 1280, "ignition window length");
    cyc(2);
    chk(ign_en === 1'b0 && fault === 1'b1 && inv_en === 1'b0, "ignition fault");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    cyc(2);
    reset_i <= 1'b0;
    t_normal();
    t_corridor();
    t_filament(0);
    t_filament(1);
    t_bus95();
    t_ignite();
    results();
  end
  initial begin
    #300000;
    n_fail++;
    results();
  end
endmodule
